//--- common/otp_sec_pkg.sv
// Constants, register map and field positions for the OTP security block
package otp_sec_pkg;

    // Store geometry
    localparam int OTP_SECTORS         = 4;
    localparam int OTP_ROWS_PER_SECTOR = 512;
    localparam int OTP_WORD_W          = 32;
    localparam int OTP_MAIN_ROWS       = OTP_SECTORS * OTP_ROWS_PER_SECTOR;
    localparam int OTP_ROW_W           = 12;
    localparam int OTP_ADDR_W          = 16;
    localparam int OTP_CTRL_W          = 16;
    localparam logic [OTP_ROW_W-1:0] OTP_LAST_ROW = 12'h7FF;

    // Tile SRAM: 256 KB as 32-bit words
    localparam int SRAM_WORDS = 65536;
    localparam int SRAM_IDX_W = 16;
    localparam int SRAM_BYTE_ADDR_W = 18;

    // Security word bit positions
    localparam int SEC_NO_DEBUG        = 0;
    localparam int SEC_NO_LINK         = 1;
    localparam int SEC_SECURE_BOOT     = 5;
    localparam int SEC_REDUNDANT       = 7;
    localparam int SEC_SECTOR_LOCK_LO  = 8;
    localparam int SEC_MASTER_LOCK     = 12;
    localparam int SEC_NO_DEBUG_OTP    = 13;
    localparam int SEC_NO_GLOBAL_DEBUG = 14;
    localparam int SEC_GP_LO           = 15;
    localparam int SEC_GP_HI           = 21;
    localparam int SEC_UCX_LO          = 22;
    localparam int SEC_UCX_HI          = 31;
    localparam logic [31:0] SEC_RESET  = 32'h0000_0000;

    // Register map
    localparam logic [7:0] REG_OTP_ADDR  = 8'h00;
    localparam logic [7:0] REG_OTP_DATA  = 8'h04;
    localparam logic [7:0] REG_OTP_CTRL  = 8'h08;
    localparam logic [7:0] REG_STATUS    = 8'h0C;
    localparam logic [7:0] REG_SECURITY  = 8'h10;
    localparam logic [7:0] REG_OTP_RDATA = 8'h14;

    // Control and status bits
    localparam int CTRL_PROGRAM  = 0;
    localparam int CTRL_READ     = 1;
    localparam int CTRL_SECURITY = 2;
    localparam int STAT_RUN      = 0;
    localparam int STAT_REFUSED  = 1;
    localparam int STAT_OTP_BOOT = 2;

    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} access_size_e;

    // Row index from a programming address; bit 11 selects the spare rows
    function automatic logic [OTP_ROW_W-1:0] rowOf(input logic [OTP_ADDR_W-1:0] a);
        return a[OTP_ROW_W-1:0];
    endfunction

endpackage

//--- common/otp_port_if.sv
// Read/program port between the control logic and the OTP array
`timescale 1ns/1ps
interface otp_port_if;
    import otp_sec_pkg::*;
    logic                  rdEn;
    logic [OTP_ROW_W-1:0]  rdRow;
    logic [31:0]           rdData;
    logic                  wrEn;
    logic [OTP_ROW_W-1:0]  wrRow;
    logic [31:0]           wrData;
    logic                  secWrEn;
    logic [31:0]           secWrData;
    logic [31:0]           secWord;
    logic                  redundantEn;

    modport store (input rdEn, rdRow, wrEn, wrRow, wrData, secWrEn, secWrData,
                   redundantEn, output rdData, secWord);
    modport ctrl  (output rdEn, rdRow, wrEn, wrRow, wrData, secWrEn, secWrData,
                   redundantEn, input rdData, secWord);
endinterface

//--- rtl/otp_store.sv
// One-time-programmable array: main sectors, spare rows and security word
`timescale 1ns/1ps
module otp_store
    import otp_sec_pkg::*;
#(
    parameter int SPARE_ROWS = 16
) (
    // Clock
    input wire logic  ref_clk,
    // Control side
    otp_port_if.store port
);

    logic [31:0] mainArr [OTP_MAIN_ROWS]; // RULE_01
    logic [31:0] spareArr [SPARE_ROWS];
    logic [31:0] secWord_ff;
    logic [31:0] rdData_ff;

    // Unprogrammed cells read as zero; contents are not touched by reset
    initial begin
        for (int i = 0; i < OTP_MAIN_ROWS; i++) begin
            mainArr[i] = 32'h0000_0000;
        end
        for (int i = 0; i < SPARE_ROWS; i++) begin
            spareArr[i] = 32'h0000_0000;
        end
        secWord_ff = 32'h0000_0000;
    end

    function automatic logic spareOk(input logic [OTP_ROW_W-1:0] r);
        return r[OTP_ROW_W-1] && (int'(r[OTP_ROW_W-2:0]) < SPARE_ROWS);
    endfunction

    // Programming can only set bits, never clear them
    always @(posedge ref_clk) begin
        if (port.wrEn) begin
            if (!port.wrRow[OTP_ROW_W-1]) begin
                mainArr[port.wrRow[OTP_ROW_W-2:0]] <= mainArr[port.wrRow[OTP_ROW_W-2:0]]
                                                      | port.wrData;
            end else if (port.redundantEn && spareOk(port.wrRow)) begin
                spareArr[port.wrRow[3:0]] <= spareArr[port.wrRow[3:0]] | port.wrData;
            end
        end
        if (port.secWrEn) begin
            secWord_ff <= secWord_ff | port.secWrData;
        end
    end

    always @(posedge ref_clk) begin
        if (port.rdEn) begin
            if (!port.rdRow[OTP_ROW_W-1]) begin
                rdData_ff <= mainArr[port.rdRow[OTP_ROW_W-2:0]];
            end else if (port.redundantEn && spareOk(port.rdRow)) begin
                rdData_ff <= spareArr[port.rdRow[3:0]];
            end else begin
                rdData_ff <= 32'h0000_0000;
            end
        end
    end

    assign port.rdData  = rdData_ff;
    assign port.secWord = secWord_ff;

endmodule

//--- rtl/otp_security_config.sv
// Tile security word, OTP programming, power-up copy and tile SRAM
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// Function
// RULE_01: OTP is four lockable sectors of 512 32-bit rows, 8 KB total.
// RULE_02: Security word is loaded from OTP at power up before execution.
// RULE_03: Remaining OTP content is copied to SRAM before the tile runs.
// RULE_04: Security bit 0 refuses every debug port access to tile state and memory.
// RULE_05: Security bit 1 denies other tiles access to this tile's state.
// RULE_06: Security bit 5 bypasses boot ROM, booting from OTP address zero.
// RULE_07: Security bit 7 enables the redundant OTP rows.
// RULE_08: Security bits 8 to 11 lock programming of sectors 0 to 3.
// RULE_09: Security bit 12 rejects programming of all sectors and the security word.
// RULE_10: Security bit 13 blocks debug port reads and writes of the OTP.
// RULE_11: Security bit 14 disables the global debug sync pin both ways.
// RULE_12: Security bits 15 to 21 are a software readable general field.
// RULE_13: Security bits 22 to 31 are the user code extension.
// RULE_14: Software drives 16-bit address, 32-bit data, 16-bit control ports.
// RULE_15: One 256 KB SRAM bank, 32 bits wide, for code and data.
// RULE_16: Byte, half-word and word SRAM accesses complete in one cycle.
// RULE_17: User code extension reaches upper user code bits, zero when blank.
// RULE_18: Refused programming leaves stored contents unchanged.
// RULE_19: Reserved security bits have no effect.
module otp_security_config
    import otp_sec_pkg::*;
#(
    parameter int SPARE_ROWS = 16
) (
    // Clock and power-up reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // Software register port
    input  wire logic [7:0]                  regAddr,
    input  wire logic [31:0]                 regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [31:0]                 regRdata,
    // Processor SRAM port
    input  wire logic                        memReq,
    input  wire logic                        memWr,
    input  wire access_size_e                memSize,
    input  wire logic [SRAM_BYTE_ADDR_W-1:0] memAddr,
    input  wire logic [31:0]                 memWdata,
    output logic      [31:0]                 memRdata,
    // Remote access from debug port or other tiles
    input  wire logic                        remReq,
    input  wire logic                        remDebug,
    input  wire logic                        remOtp,
    input  wire logic                        remWr,
    input  wire logic [15:0]                 remAddr,
    input  wire logic [31:0]                 remWdata,
    output logic                             remAck,
    output logic                             remErr,
    output logic      [31:0]                 remRdata,
    // Global debug sync pin, open drain
    input  wire logic                        debugSyncInN,
    output logic                             debugSyncOut,
    output logic                             debugSyncOe,
    input  wire logic                        coreBreak,
    output logic                             debugEnterReq,
    // Tile boot and identity
    output logic                             tileRun,
    output logic                             bootFromOtp,
    output logic      [9:0]                  userCodeExt,
    output logic      [6:0]                  gpSecField
);

    typedef enum logic [1:0] {ST_LOAD, ST_COPY, ST_DRAIN, ST_RUN} boot_state_e;

    otp_port_if otp();

    otp_store #(.SPARE_ROWS(SPARE_ROWS)) u_store (
        .ref_clk (ref_clk),
        .port    (otp)
    );

    boot_state_e          state_ff;
    logic [31:0]          secReg_ff;
    logic [OTP_ROW_W-1:0] copyRow_ff;
    logic                 copyWr_ff;
    logic [SRAM_IDX_W-1:0] copyIdx_ff;
    logic [OTP_ADDR_W-1:0] otpAddr_ff;
    logic [31:0]          otpData_ff;
    logic [OTP_CTRL_W-1:0] otpCtrl_ff;
    logic [31:0]          otpRdata_ff;
    logic                 swReadPend_ff;
    logic                 remOtpRead_ff;
    logic                 refused_ff;
    logic [31:0]          sramQ_ff;
    logic [31:0]          regRdata_ff;
    logic                 remAck_ff;
    logic                 remErr_ff;
    logic                 debugEnterReq_ff;
    logic [31:0]          sram [SRAM_WORDS];

    logic                  running;
    logic                  swCtrl;
    logic                  swProg;
    logic                  swRead;
    logic                  swProgOk;
    logic                  remDenied;
    logic                  remBusy;
    logic                  remOk;
    logic                  sramWe;
    logic [SRAM_IDX_W-1:0] sramIdx;
    logic [3:0]            sramMask;
    logic [31:0]           sramData;

    // A row may be programmed only if its sector is unlocked and it exists
    function automatic logic progOk(input logic [31:0] sec, input logic [OTP_ROW_W-1:0] r);
        logic ok;
        ok = !sec[SEC_MASTER_LOCK]; // RULE_09
        if (r[OTP_ROW_W-1]) begin
            ok = ok && sec[SEC_REDUNDANT] && (int'(r[OTP_ROW_W-2:0]) < SPARE_ROWS); // RULE_07
        end else begin
            ok = ok && !sec[SEC_SECTOR_LOCK_LO + int'(r[10:9])]; // RULE_08
        end
        return ok;
    endfunction

    function automatic logic [3:0] laneMask(input access_size_e sz, input logic [1:0] off);
        case (sz)
            SZ_BYTE: laneMask = 4'h1 << off;
            SZ_HALF: laneMask = off[1] ? 4'hC : 4'h3;
            SZ_WORD: laneMask = 4'hF;
            default: laneMask = 4'h0;
        endcase
    endfunction

    // Core presents narrow data in the low lanes
    function automatic logic [31:0] laneData(input access_size_e sz, input logic [31:0] d,
                                             input logic [1:0] off);
        case (sz)
            SZ_BYTE: laneData = {4{d[7:0]}};
            SZ_HALF: laneData = {2{d[15:0]}};
            default: laneData = d;
        endcase
        if (off == 2'b00) begin
            laneData = laneData;
        end
    endfunction

    assign running = (state_ff == ST_RUN);
    assign swCtrl  = regWr && (regAddr == REG_OTP_CTRL) && running; // RULE_14
    assign swProg  = swCtrl && regWdata[CTRL_PROGRAM];
    assign swRead  = swCtrl && regWdata[CTRL_READ] && !regWdata[CTRL_PROGRAM];
    assign swProgOk = regWdata[CTRL_SECURITY] ? !secReg_ff[SEC_MASTER_LOCK]
                                              : progOk(secReg_ff, rowOf(otpAddr_ff));

    // Only the debug port may reach the OTP; other tiles never do
    always_comb begin
        remDenied = 1'b0;
        if (remDebug && secReg_ff[SEC_NO_DEBUG]) begin
            remDenied = 1'b1; // RULE_04
        end
        if (!remDebug && secReg_ff[SEC_NO_LINK]) begin
            remDenied = 1'b1; // RULE_05
        end
        if (remOtp && (!remDebug || secReg_ff[SEC_NO_DEBUG_OTP])) begin
            remDenied = 1'b1; // RULE_10
        end
        if (remOtp && remWr && !progOk(secReg_ff, rowOf(remAddr))) begin
            remDenied = 1'b1; // RULE_18
        end
    end
    assign remBusy = remOtp ? swCtrl : memReq;
    assign remOk   = remReq && running && !remDenied && !remBusy;

    // Power-up sequence: security word, then copy of the whole main array
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff   <= ST_LOAD;
            copyRow_ff <= '0;
        end else begin
            case (state_ff)
                ST_LOAD: begin
                    state_ff <= ST_COPY;
                end
                ST_COPY: begin
                    copyRow_ff <= copyRow_ff + 12'h001;
                    if (copyRow_ff == OTP_LAST_ROW) begin
                        state_ff <= ST_DRAIN; // RULE_03
                    end
                end
                ST_DRAIN: begin
                    state_ff <= ST_RUN;
                end
                ST_RUN: begin
                    state_ff <= ST_RUN;
                end
                default: begin
                    state_ff <= ST_LOAD;
                end
            endcase
        end
    end

    // Security word only changes at power up; new programming waits for the next one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            secReg_ff <= SEC_RESET;
        end else if (state_ff == ST_LOAD) begin
            secReg_ff <= otp.secWord; // RULE_02 RULE_19
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            copyWr_ff  <= 1'b0;
            copyIdx_ff <= '0;
        end else begin
            copyWr_ff  <= (state_ff == ST_COPY);
            copyIdx_ff <= SRAM_IDX_W'(copyRow_ff);
        end
    end

    // OTP port steering: copy owns it during boot, software wins over debug
    always_comb begin
        otp.rdEn        = 1'b0;
        otp.rdRow       = copyRow_ff;
        otp.wrEn        = 1'b0;
        otp.wrRow       = rowOf(otpAddr_ff);
        otp.wrData      = otpData_ff;
        otp.secWrEn     = 1'b0;
        otp.secWrData   = otpData_ff;
        otp.redundantEn = secReg_ff[SEC_REDUNDANT]; // RULE_07
        if (state_ff == ST_COPY) begin
            otp.rdEn = 1'b1; // RULE_03
        end else if (swRead) begin
            otp.rdEn  = 1'b1;
            otp.rdRow = rowOf(otpAddr_ff);
        end else if (swProg && swProgOk) begin
            otp.secWrEn = regWdata[CTRL_SECURITY]; // RULE_09
            otp.wrEn    = !regWdata[CTRL_SECURITY]; // RULE_08
        end else if (remOk && remOtp) begin
            otp.rdEn   = !remWr;
            otp.rdRow  = rowOf(remAddr);
            otp.wrEn   = remWr;
            otp.wrRow  = rowOf(remAddr);
            otp.wrData = remWdata;
        end
    end

    // Software programming registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            otpAddr_ff <= '0;
            otpData_ff <= '0;
            otpCtrl_ff <= '0;
        end else if (regWr) begin
            if (regAddr == REG_OTP_ADDR) begin
                otpAddr_ff <= regWdata[OTP_ADDR_W-1:0]; // RULE_14
            end
            if (regAddr == REG_OTP_DATA) begin
                otpData_ff <= regWdata;
            end
            if (regAddr == REG_OTP_CTRL) begin
                otpCtrl_ff <= regWdata[OTP_CTRL_W-1:0];
            end
        end
    end

    // Outcome of the latest software programming attempt
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            refused_ff <= 1'b0;
        end else if (swProg) begin
            refused_ff <= !swProgOk; // RULE_18
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            swReadPend_ff <= 1'b0;
            remOtpRead_ff <= 1'b0;
            otpRdata_ff   <= '0;
        end else begin
            swReadPend_ff <= swRead;
            remOtpRead_ff <= remOk && remOtp && !remWr;
            if (swReadPend_ff) begin
                otpRdata_ff <= otp.rdData;
            end
        end
    end

    // Single SRAM port: copy, then core, then remote
    always_comb begin
        sramWe   = 1'b0;
        sramIdx  = memAddr[SRAM_BYTE_ADDR_W-1:2];
        sramMask = 4'hF;
        sramData = remWdata;
        if (copyWr_ff) begin
            sramWe   = 1'b1; // RULE_03
            sramIdx  = copyIdx_ff;
            sramData = otp.rdData;
        end else if (memReq && running) begin
            sramWe   = memWr;
            sramMask = laneMask(memSize, memAddr[1:0]); // RULE_16
            sramData = laneData(memSize, memWdata, memAddr[1:0]);
        end else if (remOk && !remOtp) begin
            sramWe  = remWr;
            sramIdx = remAddr;
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int b = 0; b < 4; b++) begin
            if (sramWe && sramMask[b]) begin
                sram[sramIdx][b*8 +: 8] <= sramData[b*8 +: 8]; // RULE_15
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sramQ_ff <= '0;
        end else begin
            sramQ_ff <= sram[sramIdx]; // RULE_16
        end
    end

    // Remote answer one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            remAck_ff <= 1'b0;
            remErr_ff <= 1'b0;
        end else begin
            remAck_ff <= remReq;
            remErr_ff <= remReq && !remOk;
        end
    end

    // Register read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst || !regRd) begin
            regRdata_ff <= '0;
        end else begin
            case (regAddr)
                REG_OTP_ADDR:  regRdata_ff <= {16'h0000, otpAddr_ff};
                REG_OTP_DATA:  regRdata_ff <= otpData_ff;
                REG_OTP_CTRL:  regRdata_ff <= {16'h0000, otpCtrl_ff};
                REG_STATUS:    regRdata_ff <= {29'h0000_0000, secReg_ff[SEC_SECURE_BOOT],
                                               refused_ff, running};
                REG_SECURITY:  regRdata_ff <= secReg_ff; // RULE_12
                REG_OTP_RDATA: regRdata_ff <= otpRdata_ff;
                default:       regRdata_ff <= '0;
            endcase
        end
    end

    // Debug sync pin is inert when global debug is disabled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            debugEnterReq_ff <= 1'b0;
        end else begin
            debugEnterReq_ff <= running && !debugSyncInN
                                && !secReg_ff[SEC_NO_GLOBAL_DEBUG]; // RULE_11
        end
    end

    assign debugSyncOut  = 1'b0;
    assign debugSyncOe   = running && coreBreak && !secReg_ff[SEC_NO_GLOBAL_DEBUG]; // RULE_11
    assign debugEnterReq = debugEnterReq_ff;
    assign regRdata      = regRdata_ff;
    assign memRdata      = sramQ_ff;
    assign remAck        = remAck_ff;
    assign remErr        = remErr_ff;
    assign remRdata      = remOtpRead_ff ? otp.rdData : sramQ_ff;
    assign tileRun       = running;
    assign bootFromOtp   = secReg_ff[SEC_SECURE_BOOT]; // RULE_06
    assign userCodeExt   = secReg_ff[SEC_UCX_HI:SEC_UCX_LO]; // RULE_13 RULE_17
    assign gpSecField    = secReg_ff[SEC_GP_HI:SEC_GP_LO]; // RULE_12

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_debug_denied: assert property (remReq && remDebug && secReg_ff[SEC_NO_DEBUG]
        |=> remAck && remErr) else $error("debug access not refused"); // RULE_04
    a_link_denied: assert property (remReq && !remDebug && secReg_ff[SEC_NO_LINK]
        |=> remErr) else $error("tile link access not refused"); // RULE_05
    a_debug_otp: assert property (remReq && remDebug && remOtp && secReg_ff[SEC_NO_DEBUG_OTP]
        |=> remErr) else $error("debug OTP access not blocked"); // RULE_10
    a_sector_lock: assert property (otp.wrEn && !otp.wrRow[OTP_ROW_W-1]
        |-> !secReg_ff[SEC_SECTOR_LOCK_LO + int'(otp.wrRow[10:9])])
        else $error("locked sector programmed"); // RULE_08
    a_master_lock: assert property (secReg_ff[SEC_MASTER_LOCK] |-> !otp.wrEn && !otp.secWrEn)
        else $error("programming under master lock"); // RULE_09
    a_spare_rows: assert property (otp.wrEn && otp.wrRow[OTP_ROW_W-1] |-> secReg_ff[SEC_REDUNDANT])
        else $error("spare row programmed while disabled"); // RULE_07
    a_global_debug: assert property (secReg_ff[SEC_NO_GLOBAL_DEBUG] |=> !debugSyncOe && !debugEnterReq)
        else $error("debug sync pin active while disabled"); // RULE_11
    a_sec_load: assert property (state_ff == ST_LOAD |=> secReg_ff == $past(otp.secWord))
        else $error("security word not loaded"); // RULE_02
    a_run_after_copy: assert property ($rose(tileRun) |-> $past(state_ff) == ST_DRAIN
        && $past(copyWr_ff)) else $error("tile ran before copy finished"); // RULE_03
    a_refused_flag: assert property (swProg && !swProgOk |=> refused_ff && !$past(otp.wrEn))
        else $error("refused programming not reported"); // RULE_18
    a_word_write: assert property (memReq && memWr && memSize == SZ_WORD && running
        |=> sram[$past(memAddr[SRAM_BYTE_ADDR_W-1:2])] == $past(memWdata))
        else $error("word write not completed in one cycle"); // RULE_16

    c_boot_done: cover property ($rose(tileRun));
    c_prog_ok: cover property (swProg && swProgOk);
    c_remote_read: cover property (remReq && remOk && !remWr ##1 remAck && !remErr);
    c_byte_write: cover property (memReq && memWr && memSize == SZ_BYTE && running);

endmodule

//--- testbench/sync_pin_model.sv
// Open-drain debug sync line with its pull-up and a peer tile on it
`timescale 1ns/1ps
module sync_pin_model (
    // Drivers on the line
    input  wire logic tileOe,
    input  wire logic peerPullLow,
    // Resolved line level
    output logic      lineN
);
    // The pull-up wins unless some party pulls low
    assign lineN = !(tileOe || peerPullLow);
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the OTP security block
`timescale 1ns/1ps
module tb_top;
    import otp_sec_pkg::*;
    logic         ref_clk = 0, rst = 1, regWr = 0, regRd = 0, memReq = 0, memWr = 0;
    logic         remReq = 0, remDebug = 0, remOtp = 0, remWr = 0, coreBreak = 0, peerLow = 0;
    logic         rdPend = 0, mPend = 0, remAck, remErr, tileRun, bootFromOtp;
    logic         debugSyncOut, debugSyncOe, debugEnterReq;
    wire          debugSyncInN;
    logic [7:0]   regAddr = 0;
    logic [17:0]  memAddr = 0;
    logic [15:0]  remAddr = 0;
    logic [31:0]  regWdata = 0, memWdata = 0, remWdata = 0, regRdata, memRdata, remRdata, w, d;
    logic [9:0]   userCodeExt;
    logic [6:0]   gpSecField;
    logic [32:0]  expQ[$];
    access_size_e memSize = SZ_WORD;
    int           miscompares = 0, n_tests = 0, seed = 32'h593b_5194;

    otp_security_config i_dut (.*);
    sync_pin_model i_pin (.tileOe(debugSyncOe && !debugSyncOut), .peerPullLow(peerLow),
                          .lineN(debugSyncInN));

    always #2 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Each answer is matched against the oldest expectation
    always @(posedge ref_clk) begin
        rdPend <= regRd;
        mPend <= memReq && !memWr;
        if (rdPend) chk("regRdata", expQ.pop_front(), {1'b0, regRdata});
        if (mPend) chk("memRdata", expQ.pop_front(), {1'b0, memRdata});
        if (remAck) chk("remote", expQ.pop_front(), {remErr, remErr ? 32'h0 : remRdata});
    end

    task automatic regOp(input logic wr, input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        if (!wr) expQ.push_back({1'b0, v});
        regWr <= wr;
        regRd <= !wr;
        regAddr <= a;
        regWdata <= v;
        @(posedge ref_clk);
        regWr <= 0;
        regRd <= 0;
    endtask

    task automatic memOp(input logic wr, input access_size_e s, input logic [17:0] a,
                         input logic [31:0] v);
        @(posedge ref_clk);
        if (!wr) expQ.push_back({1'b0, v});
        memReq <= 1;
        memWr <= wr;
        memSize <= s;
        memAddr <= a;
        memWdata <= v;
        @(posedge ref_clk);
        memReq <= 0;
    endtask

    task automatic remOp(input logic dbg, input logic o, input logic [15:0] a,
                         input logic [32:0] e);
        @(posedge ref_clk);
        expQ.push_back(e);
        remReq <= 1;
        remDebug <= dbg;
        remOtp <= o;
        remAddr <= a;
        remWdata <= $random(seed);
        @(posedge ref_clk);
        remReq <= 0;
    endtask

    // Address, data, then control: the control write launches the operation
    task automatic prog(input logic [15:0] c, input logic [15:0] a, input logic [31:0] v);
        regOp(1, REG_OTP_ADDR, {16'h0000, a});
        regOp(1, REG_OTP_DATA, v);
        regOp(1, REG_OTP_CTRL, {16'h0000, c});
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic doReset();
        rst <= 1;
        repeat (20) @(posedge ref_clk);
        rst <= 0;
        for (int i = 0; i < 2200 && tileRun !== 1'b1; i++) @(posedge ref_clk);
        chk("tileRun", 1, tileRun);
    endtask

    initial begin
        doReset();
        regOp(0, REG_SECURITY, 32'h0000_0000);
        chk("userCodeExt", 0, userCodeExt);
        chk("bootFromOtp", 0, bootFromOtp);
        w = $random(seed);
        memOp(1, SZ_WORD, 18'h100, w);
        memOp(1, SZ_BYTE, 18'h101, 32'h0000_00A5);
        memOp(0, SZ_WORD, 18'h100, {w[31:16], 8'hA5, w[7:0]});
        remOp(1, 0, 16'h0040, {1'b0, w[31:16], 8'hA5, w[7:0]});
        remOp(0, 0, 16'h0040, {1'b0, w[31:16], 8'hA5, w[7:0]});
        coreBreak <= 1;
        repeat (3) @(posedge ref_clk);
        chk("debugSyncOe", 1, debugSyncOe);
        chk("debugEnterReq", 1, debugEnterReq);
        coreBreak <= 0;
        d = $random(seed);
        prog(16'h0001, 16'h0005, d);
        prog(16'h0002, 16'h0005, 32'h0000_0000);
        regOp(0, REG_OTP_RDATA, d);
        remOp(1, 1, 16'h0005, {1'b0, d});
        remOp(0, 1, 16'h0005, {1'b1, 32'h0});
        prog(16'h0001, 16'h0803, w);
        regOp(0, REG_STATUS, 32'h0000_0003);
        // Lock sector 0, shut out debug and links, set boot, spare, field and reserved bits
        prog(16'h0005, 16'h0000, 32'h0040_E1FF);
        doReset();
        regOp(0, REG_SECURITY, 32'h0040_E1FF);
        chk("userCodeExt", 10'h001, userCodeExt);
        chk("gpSecField", 7'h01, gpSecField);
        chk("bootFromOtp", 1, bootFromOtp);
        memOp(0, SZ_WORD, 18'h14, d);
        remOp(1, 0, 16'h0040, {1'b1, 32'h0});
        remOp(1, 1, 16'h0005, {1'b1, 32'h0});
        remOp(0, 0, 16'h0040, {1'b1, 32'h0});
        coreBreak <= 1;
        peerLow <= 1;
        repeat (3) @(posedge ref_clk);
        chk("debugSyncOe", 0, debugSyncOe);
        chk("debugEnterReq", 0, debugEnterReq);
        coreBreak <= 0;
        peerLow <= 0;
        prog(16'h0001, 16'h0005, ~d);
        regOp(0, REG_STATUS, 32'h0000_0007);
        prog(16'h0002, 16'h0005, 32'h0000_0000);
        regOp(0, REG_OTP_RDATA, d);
        prog(16'h0001, 16'h0803, w);
        prog(16'h0002, 16'h0803, 32'h0000_0000);
        regOp(0, REG_OTP_RDATA, w);
        prog(16'h0005, 16'h0000, 32'h0000_1000);
        doReset();
        prog(16'h0005, 16'h0000, 32'h0002_0000);
        regOp(0, REG_STATUS, 32'h0000_0007);
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        complete_run();
    end
endmodule
